//--- sddrv_pkg.sv
// segment display driver: shared constants, carriers and segment cell
package sddrv_pkg;

  // ------------------------------------------------------------------
  // panel geometry
  // ------------------------------------------------------------------
  localparam int COM_LINES = 4;
  localparam int SEG_LINES = 15;
  localparam int DOTS_PER_SEG = 4;
  localparam int SEG_ADDR_W = 4;
  localparam logic [SEG_ADDR_W-1:0] SEG_ADDR_LAST = 4'he;

  // ------------------------------------------------------------------
  // frame timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_PERIOD_NS = 16_000_000; // 62.5 Hz frame
  localparam int SLOTS_PER_FRAME = 8;
  localparam int SLOT_TIME_NS = FRAME_PERIOD_NS / SLOTS_PER_FRAME;
  localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 15;
  localparam int SLOT_W = 3;
  localparam int SLOT_HALF_BIT = 2; // high half: commons inverted
  localparam int SLOT_COM_W = 2;    // low bits pick the selected common
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h7;

  // ------------------------------------------------------------------
  // display start register
  // ------------------------------------------------------------------
  localparam int START_W = 4;
  localparam int START_EN_BIT = 3;
  localparam logic [START_W-1:0] START_RESET = 4'h0;

  // ------------------------------------------------------------------
  // drive levels of a common line
  // ------------------------------------------------------------------
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_FULL = 2'h2;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [SEG_ADDR_W-1:0] addr;
    logic [DOTS_PER_SEG-1:0] mask; // bit-wise writes keep unmasked dots
    logic [DOTS_PER_SEG-1:0] data;
  } sddrv_wr_t;

  typedef struct packed {
    logic [COM_LINES-1:0][1:0] common_line;
    logic [SEG_LINES-1:0] segment_line;
  } sddrv_panel_t;

endpackage : sddrv_pkg

`timescale 1ns/1ps

// ------------------------------------------------------------------
// one segment line: picks the dot of the selected common
// ------------------------------------------------------------------
module sddrv_seg_cell
  import sddrv_pkg::*;
(
  input wire logic [DOTS_PER_SEG-1:0] dots,
  input wire logic [SLOT_W-1:0] slot,
  output logic seg_level
);

  logic dot_on;

  // lit dot sits opposite its common, unlit one follows it
  always_comb begin
    dot_on = dots[slot[SLOT_COM_W-1:0]];
    seg_level = dot_on ^ ~slot[SLOT_HALF_BIT]; // RL9
  end

endmodule : sddrv_seg_cell

//--- sddrv_top.sv
// segment display driver: dot memory, frame timing and panel drive
// Notes on behaviour
// (RL1) four commons by fifteen segments, sixty dots
// (RL2) quarter duty, half bias, 62.5 Hz frame
// (RL3) doubler runs only with enable set
// (RL4) nibble holds four dots, one lights
// (RL5) dot memory written and read like data memory
// (RL6) waveforms only while enable is one
// (RL7) inactive display drives every line low
// (RL8) commons three-level, staggered one eighth frame
// (RL9) segment two-level, phase chosen by dot bits
// (RL10) dot lit where levels differ fully
// (RL11) enable is bit three of start register
// (RL12) power-on reset darkens panel, dots undefined
// (RL13) clock stop darkens panel, dots kept
// (RL14) halt and soft reset keep waveforms running
// (RL15) eight equal slots per frame from clock
`timescale 1ns/1ps

module sddrv_top
  import sddrv_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic stop_mode,
  input wire sddrv_wr_t seg_wr,
  input wire logic [SEG_ADDR_W-1:0] seg_rd_addr,
  output logic [DOTS_PER_SEG-1:0] seg_rd_data,
  input wire logic start_wr_en,
  input wire logic [START_W-1:0] start_wr_data,
  output logic [START_W-1:0] start_rd_data,
  output logic doubler_run,
  output sddrv_panel_t panel
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOT_CYCLES_P - 1);

  logic [DOTS_PER_SEG-1:0] seg_mem_q [SEG_LINES];
  logic [DOTS_PER_SEG-1:0] seg_mem_d [SEG_LINES];
  logic [DOTS_PER_SEG-1:0] rd_data_q, rd_data_d;
  logic [START_W-1:0] start_q, start_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [SLOT_W-1:0] slot_q, slot_d;
  logic dbl_q, dbl_d;
  sddrv_panel_t panel_q, panel_d;
  logic [SEG_LINES-1:0] seg_wave;
  logic active;

  // ------------------------------------------------------------------
  // dot memory: no reset, contents undefined at power-on
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < SEG_LINES; i++) begin
      seg_mem_d[i] = seg_mem_q[i];
      if (seg_wr.en && seg_wr.addr == SEG_ADDR_W'(i)) begin
        // masked merge serves whole-nibble and single-bit writes
        seg_mem_d[i] = (seg_mem_q[i] & ~seg_wr.mask)
                     | (seg_wr.data & seg_wr.mask); // RL5 RL4
      end
    end
    rd_data_d = '0; // unmapped nibbles read as zero
    if (seg_rd_addr <= SEG_ADDR_LAST) begin
      rd_data_d = seg_mem_q[seg_rd_addr]; // RL5
    end
  end

  // dots survive stop, halt and resets alike
  always_ff @(posedge ref_clk) begin
    seg_mem_q <= seg_mem_d; // RL12 RL13 RL14
  end

  // ------------------------------------------------------------------
  // start register, slot timing and doubler gate
  // ------------------------------------------------------------------
  always_comb begin
    start_d = start_q;
    if (start_wr_en) begin
      start_d = start_wr_data;
    end
    // stop freezes the oscillator, so the timebase holds still too
    active = start_q[START_EN_BIT] & ~stop_mode; // RL11 RL6 RL13
    div_d = div_q;
    slot_d = slot_q;
    if (!stop_mode) begin
      if (div_q == DIV_LAST) begin
        div_d = '0;
        slot_d = slot_q + 1'b1; // RL15 RL2
      end else begin
        div_d = div_q + 1'b1;
      end
    end
    dbl_d = active; // RL3
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_q <= START_RESET;
      div_q <= '0;
      slot_q <= '0;
      dbl_q <= 1'b0;
    end else begin
      start_q <= start_d;
      div_q <= div_d;
      slot_q <= slot_d;
      dbl_q <= dbl_d;
    end
  end

  // ------------------------------------------------------------------
  // segment waveforms, one cell per line
  // ------------------------------------------------------------------
  for (genvar s = 0; s < SEG_LINES; s++) begin : g_seg // RL1
    sddrv_seg_cell u_cell (
      .dots(seg_mem_q[s]),
      .slot(slot_q),
      .seg_level(seg_wave[s])
    );
  end

  // ------------------------------------------------------------------
  // panel drive
  // ------------------------------------------------------------------
  // common k is full in slot k and ground in slot k+4, mid otherwise
  always_comb begin
    panel_d = '0; // RL7
    if (active) begin
      for (int k = 0; k < COM_LINES; k++) begin
        if (slot_q[SLOT_COM_W-1:0] == SLOT_COM_W'(k)) begin
          panel_d.common_line[k] = slot_q[SLOT_HALF_BIT] ? LVL_GND
                                                         : LVL_FULL; // RL8
        end else begin
          panel_d.common_line[k] = LVL_MID; // RL2
        end
      end
      panel_d.segment_line = seg_wave; // RL10
    end
  end

  // halt and soft reset never reach here, so waveforms carry on
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      panel_q <= '0; // RL12
      rd_data_q <= '0;
    end else begin
      panel_q <= panel_d; // RL14
      rd_data_q <= rd_data_d;
    end
  end

  assign panel = panel_q;
  assign doubler_run = dbl_q;
  assign seg_rd_data = rd_data_q;
  assign start_rd_data = start_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_reset_dark: assert property (disable iff (1'b0) // RL12
    sys_rst |=> (panel == '0 && !doubler_run))
    else $error("panel not dark after reset");

  a_blank_when_off: assert property ( // RL6
    (!start_q[START_EN_BIT] || stop_mode) |=> panel == '0)
    else $error("panel driven while display off");

  a_low_when_idle: assert property ( // RL7
    (panel.common_line != '0) |-> $past(active))
    else $error("common driven without active display");

  a_doubler_gate: assert property ( // RL3
    doubler_run |-> $past(start_q[START_EN_BIT]) && !$past(stop_mode))
    else $error("doubler running with enable clear");

  a_com_stagger: assert property ( // RL8
    (panel.common_line[1] == LVL_FULL) |-> $past(slot_q) == 3'h1)
    else $error("common one full in wrong slot");

  // panel after a reset edge is dark whatever active was before it
  a_mid_present: assert property ( // RL14
    ($past(active) && !$past(sys_rst))
      |-> panel.common_line[0] == LVL_MID
       || panel.common_line[2] == LVL_MID)
    else $error("running display lost its mid level");

  a_dot_lit: assert property ( // RL10
    (panel.common_line[0] == LVL_FULL && !panel.segment_line[0])
      |-> $past(seg_mem_q[0][0]))
    else $error("segment zero lit without its dot bit");

  // a one-edge reset pulls the slot back without a slot period
  a_slot_steps: assert property ( // RL15
    (!$past(sys_rst) && slot_q != $past(slot_q))
      |-> $past(div_q) == DIV_LAST)
    else $error("slot advanced before slot period");

  a_stop_keeps: assert property ( // RL13
    (stop_mode && !seg_wr.en) |=> $stable(seg_mem_q[0]))
    else $error("dots lost during clock stop");

  a_start_bit: assert property ( // RL11
    start_wr_en |=> start_q[START_EN_BIT] == $past(start_wr_data[3]))
    else $error("enable not taken from bit three");

  c_dot_lit: cover property (
    panel.common_line[3] == LVL_FULL && !panel.segment_line[14]);
  c_frame_wrap: cover property (active && slot_q == SLOT_LAST ##1
    slot_q == '0);
  c_stop_entry: cover property (active ##1 stop_mode);
  c_stop_release: cover property (stop_mode ##1 !stop_mode);
  c_reset_active: cover property (disable iff (1'b0)
    active ##1 sys_rst);

endmodule : sddrv_top

//--- sddrv_glass.sv
// passive glass model: a dot lights under full swing
`timescale 1ns/1ps

module sddrv_glass
  import sddrv_pkg::*;
(
  input wire sddrv_panel_t panel,
  output logic [COM_LINES-1:0][SEG_LINES-1:0] lit
);
  // mid level on a common never gives full swing, so it stays dark
  always_comb begin
    for (int c = 0; c < COM_LINES; c++) begin
      for (int n = 0; n < SEG_LINES; n++) begin
        lit[c][n] = (panel.common_line[c] == LVL_FULL &&
          !panel.segment_line[n]) || (panel.common_line[c] == LVL_GND &&
          panel.segment_line[n]);
      end
    end
  end
endmodule : sddrv_glass

//--- tb_segment_display_driver.sv
// testbench for the segment display driver
`timescale 1ns/1ps

module tb_segment_display_driver
  import sddrv_pkg::*;
;
  localparam int SC = 4; // short slot keeps the run brief
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic stop_mode = 1'b0;
  sddrv_wr_t seg_wr = '0;
  logic [SEG_ADDR_W-1:0] seg_rd_addr = 4'h0;
  logic [DOTS_PER_SEG-1:0] seg_rd_data;
  logic start_wr_en = 1'b0;
  logic [START_W-1:0] start_wr_data = 4'h0;
  logic [START_W-1:0] start_rd_data;
  logic doubler_run;
  sddrv_panel_t panel;
  logic [COM_LINES-1:0][SEG_LINES-1:0] lit;
  logic [3:0] dots [SEG_LINES];
  int miscompares = 0;
  int num_checks = 0;

  sddrv_top #(.SLOT_CYCLES_P(SC)) uut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .stop_mode(stop_mode), .seg_wr(seg_wr),
    .seg_rd_addr(seg_rd_addr), .seg_rd_data(seg_rd_data),
    .start_wr_en(start_wr_en), .start_wr_data(start_wr_data),
    .start_rd_data(start_rd_data), .doubler_run(doubler_run),
    .panel(panel));
  sddrv_glass glass (.panel(panel), .lit(lit));

  // 100 ns clock
  always #50 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic wr_seg(input logic [3:0] a, input logic [3:0] m,
      input logic [3:0] d);
    seg_wr = '{1'b1, a, m, d};
    for (int i = 0; i < 4; i++) if (m[i] && a < 15) dots[a][i] = d[i];
    tick(1);
    seg_wr.en = 1'b0;
    tick(1); // strobe low across one edge before the next write
  endtask : wr_seg

  task automatic wr_start(input logic [3:0] d);
    start_wr_en = 1'b1;
    start_wr_data = d;
    tick(1);
    start_wr_en = 1'b0;
  endtask : wr_start

  // level of every line in slot s, worked out from the dot table
  function automatic sddrv_panel_t exp_panel(input int s);
    sddrv_panel_t p;
    for (int c = 0; c < COM_LINES; c++)
      p.common_line[c] = (c != s % 4) ? LVL_MID : (s < 4) ? LVL_FULL : LVL_GND;
    for (int n = 0; n < SEG_LINES; n++)
      p.segment_line[n] = dots[n][s % 4] ^ (s < 4);
    return p;
  endfunction : exp_panel

  task automatic t_memory();
    for (int n = 0; n < 15; n++) wr_seg(n[3:0], 4'hf, n[3:0] ^ 4'ha);
    wr_seg(4'h3, 4'h1, 4'h0); // single dot cleared, others kept
    wr_seg(4'hf, 4'hf, 4'hf);
    for (int n = 0; n < 16; n++) begin
      seg_rd_addr = n[3:0];
      tick(1);
      chk(seg_rd_data, (n < 15) ? dots[n] : 4'h0);
    end
    wr_start(4'h7);
    chk(start_rd_data, 4'h7);
    tick(1);
    chk(doubler_run, 1'b0);
    chk(panel, '0);
    $display("test memory done");
  endtask : t_memory

  task automatic t_frame();
    int i;
    logic [SEG_LINES-1:0] e;
    wr_start(4'h8);
    chk(start_rd_data, 4'h8);
    tick(1);
    chk(doubler_run, 1'b1);
    i = 0;
    while (panel.common_line[0] !== LVL_GND && i < 100) begin
      tick(1);
      i++;
    end
    while (panel.common_line[0] !== LVL_FULL && i < 200) begin
      tick(1);
      i++;
    end
    if (i >= 200) begin
      miscompares++;
      $display("CHECK FAILED at %0t: frame start not found", $time);
      return;
    end
    for (int s = 0; s < 8; s++) begin
      for (int n = 0; n < SEG_LINES; n++) e[n] = dots[n][s % 4];
      chk(lit[s % 4], e);
      for (int k = 0; k < SC; k++) begin
        chk(panel, exp_panel(s));
        tick(1);
      end
    end
    chk(panel, exp_panel(0));
    $display("test frame done");
  endtask : t_frame

  task automatic t_stop();
    stop_mode = 1'b1;
    seg_rd_addr = 4'h5;
    tick(2);
    chk(panel, '0);
    chk(doubler_run, 1'b0);
    chk(seg_rd_data, dots[5]);
    stop_mode = 1'b0;
    wr_start(4'h0);
    tick(2);
    chk(panel, '0);
    chk(doubler_run, 1'b0);
    $display("test stop done");
  endtask : t_stop

  // one-edge reset in mid-run darkens the panel and clears start
  task automatic t_reset();
    wr_start(4'h8);
    tick(2);
    chk(doubler_run, 1'b1);
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    chk(panel, '0);
    chk(doubler_run, 1'b0);
    chk(start_rd_data, 4'h0);
    chk(seg_rd_data, 4'h0);
    tick(2);
    chk(panel, '0);
    $display("test reset done");
  endtask : t_reset

  // main sequence
  initial begin
    tick(3);
    sys_rst = 1'b0;
    chk(panel, '0);
    chk(start_rd_data, 4'h0);
    t_memory();
    t_frame();
    t_stop();
    t_reset();
    give_verdict();
  end
endmodule : tb_segment_display_driver
